/* File: timer_pkg.sv */
/*
  Shared constants for the dual reload down-timer block: register
  indices, reset values, widths and bus response codes.
  Assumes a single clock domain and an AXI4-Lite register bus whose
  byte address is four times the register index.
*/
`default_nettype none

package timer_pkg;

  // bus and datapath widths
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam int HALF_W = 16;
  localparam int COUNT_W = 32;
  localparam int PRESCALE_W = 8;
  localparam int NUM_TIMERS = 2;

  // register indices, byte address is index * 4
  localparam logic [IDX_W-1:0] IDX_TICK_PRESCALE = 16'hc030;
  localparam logic [IDX_W-1:0] IDX_TIMER_ENABLES = 16'hc031;
  localparam logic [IDX_W-1:0] IDX_FIRST_RELOAD_LOW = 16'hc034;
  localparam logic [IDX_W-1:0] IDX_FIRST_RELOAD_HIGH = 16'hc035;
  localparam logic [IDX_W-1:0] IDX_FIRST_COUNT_LOW = 16'hc036;
  localparam logic [IDX_W-1:0] IDX_FIRST_COUNT_HIGH = 16'hc037;
  localparam logic [IDX_W-1:0] IDX_SECOND_RELOAD_LOW = 16'hc038;
  localparam logic [IDX_W-1:0] IDX_SECOND_RELOAD_HIGH = 16'hc039;
  localparam logic [IDX_W-1:0] IDX_SECOND_COUNT_LOW = 16'hc03a;
  localparam logic [IDX_W-1:0] IDX_SECOND_COUNT_HIGH = 16'hc03b;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hc03c;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hc03d;

  // values after reset
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 8'h00;
  localparam logic [NUM_TIMERS-1:0] ENABLES_RST = 2'h0;
  localparam logic [COUNT_W-1:0] VALUE_RST = 32'h0000_0000;
  localparam logic [NUM_TIMERS-1:0] IRQ_RST = 2'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_pkg

`default_nettype wire

/* File: tick_prescaler.sv */
/*
  Shared tick generator: one pulse every (divide + 1) master clocks.
  Assumes divide is a stable register value; a shrinking divide ends
  the current period at once instead of wrapping through 255.
*/
`default_nettype none

module tick_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [timer_pkg::PRESCALE_W-1:0] divide,
  output logic tick
);
  import timer_pkg::*;

  logic [PRESCALE_W-1:0] phase;

  // >= rather than == so a lowered divide never stalls the ticks
  assign tick = (phase >= divide);

  // phase counter, restarts on each tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= '0;
    end else if (tick) begin
      phase <= '0;
    end else begin
      phase <= phase + 8'h01;
    end
  end

  // judged looking back, so a divide rewritten mid-period is not blamed
  a_tick_rate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($past(tick, 3) && divide == 8'h02 && $past(divide) == 8'h02
      && $past(divide, 2) == 8'h02 && $past(divide, 3) == 8'h02)
      |-> (tick && !$past(tick) && !$past(tick, 2)))
    else $error("tick spacing differs from divide plus one");

endmodule // tick_prescaler

`default_nettype wire

/* File: down_counter.sv */
/*
  One 32-bit auto-reload down-counter with software-writable halves.
  Assumes tick is a one-cycle pulse from the shared prescaler and that
  the start value is held in a register outside.
*/
`default_nettype none

module down_counter #(
  parameter int WIDTH = timer_pkg::COUNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic load_low,
  input wire logic load_high,
  input wire logic [WIDTH/2-1:0] load_value,
  input wire logic [WIDTH-1:0] start_value,
  output logic [WIDTH-1:0] count,
  output logic underflow
);
  import timer_pkg::*;

  logic enable_q;
  logic start;
  logic expire;
  logic loading;

  assign loading = load_low | load_high;
  assign start = enable & ~enable_q;
  // zero reached on a tick: next step goes past zero
  assign expire = enable & tick & ~start & (count == '0);

  // enable edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable;
    end
  end

  // software write wins over counting so the new delay is exact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (loading) begin
      if (load_low) begin
        count[WIDTH/2-1:0] <= load_value;
      end
      if (load_high) begin
        count[WIDTH-1:WIDTH/2] <= load_value;
      end
    end else if (start) begin
      count <= start_value;
    end else if (enable && tick) begin
      if (count == '0) begin
        count <= start_value;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  // one pulse per underflow, none while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underflow <= 1'b0;
    end else begin
      underflow <= expire & ~loading;
    end
  end

  a_start_loads: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (start && !loading) |=> count == $past(start_value))
    else $error("start value not loaded on enable");

  a_count_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (enable && tick && !start && !loading && count != '0)
      |=> count == $past(count) - 1)
    else $error("counter did not step down by one");

  a_wrap_reload: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (expire && !loading) |=> (underflow && count == $past(start_value)))
    else $error("no reload or pulse past zero");

  a_hold_disabled: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!enable && !loading) |=> ($stable(count) && !underflow))
    else $error("disabled counter moved or fired");

  a_pulse_cause: assert property (
    @(posedge aclk) disable iff (!aresetn)
    underflow |-> ($past(count) == '0 && $past(enable) && $past(tick)))
    else $error("underflow pulse without a zero count");

endmodule // down_counter

`default_nettype wire

/* File: dual_reload_down_timer.sv */
/*
  Two auto-reload down-timers behind an AXI4-Lite register slave,
  sharing one tick prescaler, with a sticky status and mask pair that
  drives a single level interrupt, plus one pulse output per timer.
  Assumes one clock (aclk) and a master that keeps AXI4-Lite rules.
*/
`default_nettype none

module dual_reload_down_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic first_timer_irq,
  output logic second_timer_irq
);
  import timer_pkg::*;

  // per-timer register indices, timer one first
  localparam logic [IDX_W-1:0] RELOAD_LOW_IDX [NUM_TIMERS] =
    '{IDX_FIRST_RELOAD_LOW, IDX_SECOND_RELOAD_LOW};
  localparam logic [IDX_W-1:0] RELOAD_HIGH_IDX [NUM_TIMERS] =
    '{IDX_FIRST_RELOAD_HIGH, IDX_SECOND_RELOAD_HIGH};
  localparam logic [IDX_W-1:0] COUNT_LOW_IDX [NUM_TIMERS] =
    '{IDX_FIRST_COUNT_LOW, IDX_SECOND_COUNT_LOW};
  localparam logic [IDX_W-1:0] COUNT_HIGH_IDX [NUM_TIMERS] =
    '{IDX_FIRST_COUNT_HIGH, IDX_SECOND_COUNT_HIGH};

  // word index of a byte address; low two bits are ignored
  function automatic logic [IDX_W-1:0] word_index(
    input logic [ADDR_W-1:0] addr
  );
    word_index = addr[ADDR_W-1:2];
  endfunction

  // true for any index that holds a register
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    logic hit;
    hit = (idx == IDX_TICK_PRESCALE) || (idx == IDX_TIMER_ENABLES)
      || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      hit = hit || (idx == RELOAD_LOW_IDX[i])
        || (idx == RELOAD_HIGH_IDX[i]) || (idx == COUNT_LOW_IDX[i])
        || (idx == COUNT_HIGH_IDX[i]);
    end
    is_mapped = hit;
  endfunction

  // merge a 16-bit write into an old value by byte lane
  function automatic logic [HALF_W-1:0] merge16(
    input logic [HALF_W-1:0] old,
    input logic [HALF_W-1:0] data,
    input logic [1:0] strb
  );
    merge16 = {strb[1] ? data[15:8] : old[15:8],
               strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // write channel holding registers
  logic aw_full;
  logic [IDX_W-1:0] aw_idx;
  logic w_full;
  logic [HALF_W-1:0] wdata_q;
  logic [1:0] wstrb_q;
  logic do_write;

  // software-visible state
  logic [PRESCALE_W-1:0] tick_prescale;
  logic [NUM_TIMERS-1:0] timer_enables;
  logic [COUNT_W-1:0] reload_value_register [NUM_TIMERS];
  logic [COUNT_W-1:0] live_count_pair [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] irq_status;
  logic [NUM_TIMERS-1:0] irq_mask;

  // timer plumbing
  logic tick;
  logic [NUM_TIMERS-1:0] underflow;
  logic [NUM_TIMERS-1:0] load_low;
  logic [NUM_TIMERS-1:0] load_high;
  logic [HALF_W-1:0] load_low_value [NUM_TIMERS];
  logic [HALF_W-1:0] load_high_value [NUM_TIMERS];

  // read side
  logic [IDX_W-1:0] rd_idx;
  logic [HALF_W-1:0] rd_word;

  // one write at a time: new address and data are taken in, but the held write waits for the previous response
  assign s_axi_awready = ~aw_full;
  assign s_axi_wready = ~w_full;
  assign do_write = aw_full & w_full & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_idx <= '0;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (s_axi_awvalid && !aw_full) begin
      aw_full <= 1'b1;
      aw_idx <= word_index(s_axi_awaddr);
    end
  end

  // write data capture; registers are 16 bits, upper lanes dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (s_axi_wvalid && !w_full) begin
      w_full <= 1'b1;
      wdata_q <= s_axi_wdata[HALF_W-1:0];
      wstrb_q <= s_axi_wstrb[1:0];
    end
  end

  // write response, one cycle after address and data are both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // shared prescale register, low lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_prescale <= PRESCALE_RST;
    end else if (do_write && aw_idx == IDX_TICK_PRESCALE && wstrb_q[0]) begin
      tick_prescale <= wdata_q[PRESCALE_W-1:0];
    end
  end

  // enable bits, one per timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_enables <= ENABLES_RST;
    end else if (do_write && aw_idx == IDX_TIMER_ENABLES && wstrb_q[0]) begin
      timer_enables <= wdata_q[NUM_TIMERS-1:0];
    end
  end

  // set beats write-one-to-clear so no underflow is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= IRQ_RST;
    end else if (do_write && aw_idx == IDX_IRQ_STATUS && wstrb_q[0]) begin
      irq_status <= (irq_status & ~wdata_q[NUM_TIMERS-1:0]) | underflow;
    end else begin
      irq_status <= irq_status | underflow;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= IRQ_RST;
    end else if (do_write && aw_idx == IDX_IRQ_MASK && wstrb_q[0]) begin
      irq_mask <= wdata_q[NUM_TIMERS-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);
  // raw per-timer requests, one pulse per underflow
  assign first_timer_irq = underflow[0];
  assign second_timer_irq = underflow[1];

  tick_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .divide(tick_prescale),
    .tick(tick)
  );

  // one reload register pair and counter per timer
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        reload_value_register[t] <= VALUE_RST;
      end else if (do_write && aw_idx == RELOAD_LOW_IDX[t]) begin
        reload_value_register[t][HALF_W-1:0] <=
          merge16(reload_value_register[t][HALF_W-1:0], wdata_q, wstrb_q);
      end else if (do_write && aw_idx == RELOAD_HIGH_IDX[t]) begin
        reload_value_register[t][COUNT_W-1:HALF_W] <=
          merge16(reload_value_register[t][COUNT_W-1:HALF_W], wdata_q,
                  wstrb_q);
      end
    end

    // live count writes keep unstrobed bytes of the running value
    assign load_low[t] = do_write && aw_idx == COUNT_LOW_IDX[t];
    assign load_high[t] = do_write && aw_idx == COUNT_HIGH_IDX[t];
    assign load_low_value[t] =
      merge16(live_count_pair[t][HALF_W-1:0], wdata_q, wstrb_q);
    assign load_high_value[t] =
      merge16(live_count_pair[t][COUNT_W-1:HALF_W], wdata_q, wstrb_q);

    down_counter #(
      .WIDTH(COUNT_W)
    ) u_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(timer_enables[t]),
      .tick(tick),
      .load_low(load_low[t]),
      .load_high(load_high[t]),
      .load_value(load_low[t] ? load_low_value[t] : load_high_value[t]),
      .start_value(reload_value_register[t]),
      .count(live_count_pair[t]),
      .underflow(underflow[t])
    );
  end

  // read data decode
  assign rd_idx = word_index(s_axi_araddr);
  always_comb begin
    rd_word = '0;
    if (rd_idx == IDX_TICK_PRESCALE) begin
      rd_word = {8'h00, tick_prescale};
    end
    if (rd_idx == IDX_TIMER_ENABLES) begin
      rd_word = {14'h0000, timer_enables};
    end
    if (rd_idx == IDX_IRQ_STATUS) begin
      rd_word = {14'h0000, irq_status};
    end
    if (rd_idx == IDX_IRQ_MASK) begin
      rd_word = {14'h0000, irq_mask};
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (rd_idx == RELOAD_LOW_IDX[i]) begin
        rd_word = reload_value_register[i][HALF_W-1:0];
      end
      if (rd_idx == RELOAD_HIGH_IDX[i]) begin
        rd_word = reload_value_register[i][COUNT_W-1:HALF_W];
      end
      if (rd_idx == COUNT_LOW_IDX[i]) begin
        rd_word = live_count_pair[i][HALF_W-1:0];
      end
      if (rd_idx == COUNT_HIGH_IDX[i]) begin
        rd_word = live_count_pair[i][COUNT_W-1:HALF_W];
      end
    end
  end

  // read response; halves are sampled separately, so software must
  // reread high if low wrapped between the two reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_enable_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && aw_idx == IDX_TIMER_ENABLES && wstrb_q[0])
      |=> timer_enables == $past(wdata_q[1:0]))
    else $error("enable bits differ from written value");

  a_status_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn)
    underflow[0] |=> irq_status[0])
    else $error("underflow did not set its status bit");

  a_read_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && !s_axi_rvalid && rd_idx == IDX_FIRST_COUNT_LOW)
      |=> (s_axi_rvalid
        && s_axi_rdata[15:0] == $past(live_count_pair[0][15:0])))
    else $error("count read does not show live value");

  a_read_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && !s_axi_rvalid && rd_idx == IDX_FIRST_COUNT_HIGH)
      |=> (s_axi_rdata == {16'h0000, $past(live_count_pair[0][31:16])}))
    else $error("high count read does not show live value");

  a_status_two_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    underflow[1] |=> irq_status[1])
    else $error("second underflow did not set its status bit");

  // a clear only counts when no new underflow lands in the same cycle
  a_status_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && aw_idx == IDX_IRQ_STATUS && wstrb_q[0] && wdata_q[1]
      && !underflow[1]) |=> !irq_status[1])
    else $error("status bit not cleared by a one");

  a_prescale_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && aw_idx == IDX_TICK_PRESCALE && wstrb_q[0])
      |=> tick_prescale == $past(wdata_q[7:0]))
    else $error("prescale differs from written value");

  a_count_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    load_low[0] |=> live_count_pair[0][15:0] == $past(load_low_value[0]))
    else $error("count write did not replace the live count");

endmodule // dual_reload_down_timer

`default_nettype wire

/* File: dual_reload_down_timer_tb.sv */
/*
  Self-checking bench for the dual reload down-timer: register bus,
  prescaled periods, one-shot count writes, sticky status and mask.
  Assumes timer_pkg is compiled first and one 250 MHz clock.
*/
`default_nettype none

module dual_reload_down_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic irq, t0_irq, t1_irq;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int q0[$];
  int q1[$];
  logic [15:0] regs [12] = '{IDX_TICK_PRESCALE, IDX_TIMER_ENABLES,
    IDX_FIRST_RELOAD_LOW, IDX_FIRST_RELOAD_HIGH, IDX_FIRST_COUNT_LOW,
    IDX_FIRST_COUNT_HIGH, IDX_SECOND_RELOAD_LOW, IDX_SECOND_RELOAD_HIGH,
    IDX_SECOND_COUNT_LOW, IDX_SECOND_COUNT_HIGH, IDX_IRQ_STATUS,
    IDX_IRQ_MASK};

  always #2 aclk = ~aclk;

  dual_reload_down_timer DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .first_timer_irq(t0_irq), .second_timer_irq(t1_irq)
  );

  // pulse log: cycle stamps kept per timer, the model of the periods
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (t0_irq === 1'b1) q0.push_back(cyc);
    if (t1_irq === 1'b1) q1.push_back(cyc);
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] idx, input logic [15:0] d,
                    input logic [1:0] st = 2'b11);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= {2'b00, st};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 200);
    resp = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask

  // read: rready held up from the start until rvalid is seen
  task automatic rdreg(input logic [15:0] idx);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 200);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask

  // first pulse after enable has unknown phase, so judge the last two
  task automatic per(input int t, input int exp);
    int q[$];
    q = t ? q1 : q0;
    chk("pulse count", q.size() >= 3, 1);
    if (q.size() >= 3) begin
      chk("period", q[$] - q[$-1], exp);
      chk("period prior", q[$-1] - q[$-2], exp);
    end
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    int pl[5];
    int sl[5];
    int t;
    void'($urandom(74058));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // every register comes up zero
    foreach (regs[i]) begin
      rdreg(regs[i]);
      chk("reset value", rd, 0);
    end
    chk("irq after reset", irq, 0);
    // unmapped gap: refused both ways
    rdreg(16'hc032);
    chk("unmapped resp", resp, RESP_SLVERR);
    wr(16'hc033, 16'h1234);
    chk("unmapped bresp", resp, RESP_SLVERR);
    // a low strobe alone leaves the upper byte untouched
    wr(IDX_FIRST_RELOAD_HIGH, 16'habcd, 2'b01);
    rdreg(IDX_FIRST_RELOAD_HIGH);
    chk("strobed half", rd, 32'h0000_00cd);
    wr(IDX_FIRST_RELOAD_HIGH, 16'h0000);
    // slowest ticks, so the read lands before a second step
    wr(IDX_TICK_PRESCALE, 16'h00ff);
    wr(IDX_FIRST_RELOAD_LOW, 16'd1000);
    wr(IDX_TIMER_ENABLES, 16'h0001);
    rdreg(IDX_FIRST_COUNT_LOW);
    chk("loaded", rd == 1000 || rd == 999, 1);
    rdreg(IDX_FIRST_COUNT_HIGH);
    chk("count high", rd, 0);
    rdreg(IDX_TIMER_ENABLES);
    chk("enables", rd, 1);
    rdreg(IDX_SECOND_COUNT_LOW);
    chk("other timer idle", rd, 0);
    wr(IDX_TIMER_ENABLES, 16'h0000);
    // period sweep on timer two: divide bounds, then random
    // divide two is pinned so the tick spacing check is exercised
    pl = '{255, 0, 2, 0, 0};
    sl = '{1, 0, 0, 0, 0};
    for (int k = 2; k < 5; k++) begin
      if (k > 2) pl[k] = $urandom % 4;
      sl[k] = $urandom % 7;
    end
    for (int k = 0; k < 5; k++) begin
      wr(IDX_TIMER_ENABLES, 16'h0000);
      wr(IDX_TICK_PRESCALE, 16'(pl[k]));
      wr(IDX_SECOND_RELOAD_LOW, 16'(sl[k]));
      wr(IDX_TIMER_ENABLES, 16'h0002);
      q0.delete();
      q1.delete();
      repeat (4 * (pl[k] + 1) * (sl[k] + 1) + 8) @(posedge aclk);
      per(1, (pl[k] + 1) * (sl[k] + 1));
      chk("idle timer quiet", q0.size(), 0);
    end
    wr(IDX_TIMER_ENABLES, 16'h0000);
    repeat (2) @(posedge aclk);
    q1.delete();
    // sticky status, mask gates the level line
    rdreg(IDX_IRQ_STATUS);
    chk("status", rd, 2);
    chk("masked irq", irq, 0);
    wr(IDX_IRQ_MASK, 16'h0002);
    @(posedge aclk);
    chk("irq", irq, 1);
    wr(IDX_IRQ_MASK, 16'h0001);
    @(posedge aclk);
    chk("irq other bit", irq, 0);
    wr(IDX_IRQ_STATUS, 16'h0002);
    rdreg(IDX_IRQ_STATUS);
    chk("status cleared", rd, 0);
    // disabled counter holds and accepts a new count
    rdreg(IDX_SECOND_COUNT_LOW);
    t = rd;
    repeat (40) @(posedge aclk);
    rdreg(IDX_SECOND_COUNT_LOW);
    chk("held", rd, t);
    wr(IDX_SECOND_COUNT_LOW, 16'h0007);
    rdreg(IDX_SECOND_COUNT_LOW);
    chk("count write", rd, 7);
    chk("no pulse disabled", q1.size(), 0);
    // one-shot: short count right after a pulse, then 61-cycle reloads
    wr(IDX_TICK_PRESCALE, 16'h0000);
    wr(IDX_FIRST_RELOAD_LOW, 16'd60);
    wr(IDX_TIMER_ENABLES, 16'h0001);
    q0.delete();
    t = 0;
    while (q0.size() == 0 && t < 200) begin
      @(posedge aclk);
      t++;
    end
    chk("first pulse", q0.size() > 0, 1);
    wr(IDX_FIRST_COUNT_LOW, 16'h0004);
    t = cyc;
    repeat (12) @(posedge aclk);
    chk("one shot", q0.size() == 2 && q0[1] - t < 8, 1);
    rdreg(IDX_FIRST_COUNT_LOW);
    chk("live count", rd <= 60, 1);
    repeat (130) @(posedge aclk);
    chk("reload after", q0[2] - q0[1], 61);
    chk("reload again", q0[3] - q0[2], 61);
    chk("irq timer one", irq, 1);
    complete_run();
  end
endmodule // dual_reload_down_timer_tb

`default_nettype wire
